/* File: design/i2c_smbus_regs.svh */
`ifndef I2C_SMBUS_REGS_SVH
`define I2C_SMBUS_REGS_SVH
// Operation
// R1 - Target addresses match in seven-bit or ten-bit form, chosen per address; here only the first own address can be ten-bit.
// R2 - Two own seven-bit addresses; the second is compared through a mask.
// R3 - Analog-style and digital spike filters, each selected by software.
// R4 - Digital filter length programmable from 1 to 15 kernel clocks.
// R5 - A new line level passes only after staying stable that long.
// R6 - No stop-state wakeup on address match while the digital filter runs.
// R7 - Runs on its own kernel clock; an address match wakes the chip.
// R8 - Standard, fast and fast-plus speeds: 100k, 400k and 1M bit/s.
// R9 - Packet error check byte computed, appended on send, checked on receive.
// R10 - Clock-low timeout checked and alert signalling handled in hardware.
// R11 - Address resolution and host notify addresses recognised in hardware.
// R12 - Transmit and receive data may be moved by DMA requests.

// Register byte offsets.
`define A_CTRL   6'h00
`define A_OWN1   6'h04
`define A_OWN2   6'h08
`define A_TXD    6'h0c
`define A_RXD    6'h10
`define A_STAT   6'h14
`define A_ISTAT  6'h18
`define A_ICLR   6'h1c
`define A_IEN    6'h20
`define A_PEC    6'h24
`define A_ALERT  6'h28

// Control fields.
`define F_EN     0
`define F_ANF    1
`define F_DNF    2
`define F_PEC    6
`define F_ALERT  7
`define F_ARP    8
`define F_HN     9
`define F_WAKE   10
`define F_SPD    11
`define F_TMO    13
`define F_DTX    14
`define F_DRX    15
`define CTRL_RST 16'h0002

// Own address fields, and the send bit of a transmit data write.
`define F_OA_EN  15
`define F_OA_10  10
`define F_OA_MSK 8
`define F_PSEND  8

// Interrupt event bits.
`define E_ADDR   0
`define E_RXNE   1
`define E_TXIS   2
`define E_STOP   3
`define E_NACK   4
`define E_PEC    5
`define E_TMO    6
`define E_ALERT  7

// Fixed bus addresses and codes.
`define ARP_ADDR 7'h61
`define HN_ADDR  7'h08
`define ARA_ADDR 7'h0c
`define TEN_HDR  5'h1e
`define PEC_POLY 8'h07

// Timing, in ns, and cycle counts derived from the clock period.
`define CLK_NS     10
`define ANF_NS     50
`define HOLD_SM_NS 300
`define HOLD_FM_NS 150
`define HOLD_FP_NS 50
`define TMO_NS     25000000
`define ANF_CYC ((`ANF_NS + `CLK_NS - 1) / `CLK_NS)
`define HSM_CYC ((`HOLD_SM_NS + `CLK_NS - 1) / `CLK_NS)
`define HFM_CYC ((`HOLD_FM_NS + `CLK_NS - 1) / `CLK_NS)
`define HFP_CYC ((`HOLD_FP_NS + `CLK_NS - 1) / `CLK_NS)
`define TMO_CYC (`TMO_NS / `CLK_NS)
`endif

/* File: design/i2c_smbus_pkg.sv */
package i2c_smbus_pkg;
   typedef enum logic [2:0] {
      s_idle  = 3'b000,
      s_addr  = 3'b001,
      s_ack_a = 3'b011,
      s_addr2 = 3'b010,
      s_rx    = 3'b110,
      s_ack_r = 3'b111,
      s_tx    = 3'b101,
      s_ack_t = 3'b100
   } state_t;
   typedef enum logic [2:0] {
      m_none, m_own1, m_own2, m_ten, m_arp, m_hn, m_ara
   } match_t;
endpackage : i2c_smbus_pkg

/* File: design/i2c_smbus_interface.sv */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "i2c_smbus_regs.svh"
module i2c_smbus_interface
   import i2c_smbus_pkg::*;
#(
   parameter int TMO_CYC = `TMO_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [5:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        alert_in,
   output logic             alert_out,
   output logic             alert_oe,
   input  wire logic        stop_mode,
   output logic             wake,
   output logic             irq,
   output logic             dma_tx_req,
   output logic             dma_rx_req
);
   logic [15:0] ctrl;
   logic [15:0] own1;
   logic [15:0] own2;
   logic [7:0]  ien;
   logic [7:0]  ist;
   logic [7:0]  ev;
   logic [7:0]  txd;
   logic [7:0]  rxd;
   logic        tx_full;
   logic        pec_send;
   logic        rx_full;
   logic        alert_req;
   state_t      st;
   match_t      hit;
   logic [3:0]  cnt;
   logic [7:0]  sh;
   logic [7:0]  crc;
   logic        rw;
   logic        hdr10;
   logic        ten_ok;
   logic        nack;
   logic        need_tx;
   logic        need_rx;
   logic        got_rx;
   logic        sda_low;
   logic        nd;
   logic [4:0]  hc;
   logic [4:0]  hold;
   logic [4:0]  need;
   logic [23:0] tmo;
   logic [1:0]  pin_raw;
   logic [1:0]  lvl;
   logic [1:0]  pl;
   logic        a1;
   logic        a2;
   logic        pa2;
   logic        re;
   logic        fe;
   logic        start;
   logic        stop;
   logic        tmo_hit;
   logic        load_now;
   logic        store_now;
   logic        ara_take;
   logic [6:0]  a7;
   logic [6:0]  m7;
   logic        h_own1;
   logic        h_own2;
   logic        h_10;
   logic        h_arp;
   logic        h_hn;
   logic        h_ara;
   logic        a_hit;
   logic [7:0]  tx_byte;

   // Control fields in use by the logic below.
   wire       c_en  = ctrl[`F_EN];
   wire [3:0] dnf   = ctrl[`F_DNF+3:`F_DNF];
   wire [1:0] c_spd = ctrl[`F_SPD+1:`F_SPD];

   // Filter length: analog stand-in plus digital count. [R3] [R4]
   assign need = (ctrl[`F_ANF] ? 5'(`ANF_CYC) : 5'h00) + {1'b0, dnf};
   assign pin_raw = {sda_in, scl_in};

   // Per line: two-stage synchroniser, then a stability filter.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : flt
         logic       q1;
         logic       q2;
         logic       q;
         logic [4:0] run;
         always_ff @(posedge clk) begin
            if (rst) begin
               q1  <= 1'b1;
               q2  <= 1'b1;
               q   <= 1'b1;
               run <= 5'h00;
            end else begin
               q1 <= pin_raw[g];
               q2 <= q1;
               // A level is taken only after it held long enough. [R5]
               if (q2 == q) begin
                  run <= 5'h00;
               end else if (run + 5'h01 >= need) begin
                  q   <= q2;
                  run <= 5'h00;
               end else begin
                  run <= run + 5'h01;
               end
            end
         end
         assign lvl[g] = q;
      end
   endgenerate

   // Bus edge and condition detection on the filtered lines.
   always_ff @(posedge clk) begin
      if (rst) begin
         pl  <= 2'h3;
         a1  <= 1'b1;
         a2  <= 1'b1;
         pa2 <= 1'b1;
      end else begin
         pl  <= lvl;
         a1  <= alert_in;
         a2  <= a1;
         pa2 <= a2;
      end
   end
   assign re    = lvl[0] & ~pl[0];
   assign fe    = ~lvl[0] & pl[0];
   assign start = lvl[0] & pl[0] & pl[1] & ~lvl[1];
   assign stop  = lvl[0] & pl[0] & ~pl[1] & lvl[1];

   // Data hold after the clock falls depends on the bus speed. [R8]
   always_comb begin
      unique case (c_spd)
         2'h0:    hold = 5'(`HSM_CYC);
         2'h1:    hold = 5'(`HFM_CYC);
         default: hold = 5'(`HFP_CYC);
      endcase
   end

   // Address comparators.
   assign a7 = sh[7:1];
   assign m7 = ~(7'h7f << own2[`F_OA_MSK+2:`F_OA_MSK]);
   assign h_own1 = own1[`F_OA_EN] & ~own1[`F_OA_10]
                   & (a7 == own1[6:0]);                    // [R1] [R2]
   assign h_own2 = own2[`F_OA_EN]
                   & (((a7 ^ own2[7:1]) & ~m7) == 7'h00);  // [R2]
   assign h_10   = own1[`F_OA_EN] & own1[`F_OA_10]
                   & (sh[7:3] == `TEN_HDR)
                   & (sh[2:1] == own1[9:8])
                   & (~sh[0] | ten_ok);                    // [R1]
   assign h_arp  = ctrl[`F_ARP] & (a7 == `ARP_ADDR);       // [R11]
   assign h_hn   = ctrl[`F_HN] & (a7 == `HN_ADDR);         // [R11]
   assign h_ara  = alert_req & sh[0] & (a7 == `ARA_ADDR);  // [R10]
   assign a_hit  = h_own1 | h_own2 | h_10 | h_arp | h_hn | h_ara;
   assign ara_take = fe & (st == s_addr) & (cnt == 4'h8) & h_ara;

   // Buffer hand-offs; the bus clock is held low while waiting on them.
   assign load_now  = need_tx & (tx_full | pec_send);
   assign store_now = need_rx & ~rx_full;
   assign tx_byte   = pec_send ? crc : txd;                // [R9]
   assign tmo_hit   = (tmo == 24'(TMO_CYC - 1));

   // Clock-low timeout runs only while this target takes part. [R10]
   always_ff @(posedge clk) begin
      if (rst || lvl[0] || !ctrl[`F_TMO] || st == s_idle) begin
         tmo <= 24'h000000;
      end else begin
         tmo <= tmo + 24'h000001;
      end
   end

   // Target sequencer, check byte and drive of the data line.
   always_ff @(posedge clk) begin
      ev <= 8'h00;
      if (rst || !c_en) begin
         st      <= s_idle;
         hit     <= m_none;
         cnt     <= 4'h0;
         sh      <= 8'h00;
         crc     <= 8'h00;
         rw      <= 1'b0;
         hdr10   <= 1'b0;
         ten_ok  <= 1'b0;
         nack    <= 1'b0;
         need_tx <= 1'b0;
         need_rx <= 1'b0;
         got_rx  <= 1'b0;
         sda_low <= 1'b0;
         nd      <= 1'b0;
         hc      <= 5'h00;
         wake    <= 1'b0;
      end else begin
         if (hc == 5'h01) sda_low <= nd;
         if (hc != 5'h00) hc <= hc - 5'h01;
         if (!stop_mode) wake <= 1'b0;
         // Each address and data bit enters the check byte as it is sampled; acknowledge bits do not. [R9]
         if (re && cnt < 4'h8 && st inside {s_addr, s_addr2, s_rx, s_tx})
         begin
            crc <= {crc[6:0], 1'b0}
                   ^ ((crc[7] ^ lvl[1]) ? `PEC_POLY : 8'h00);
            cnt <= cnt + 4'h1;
            if (st != s_tx) sh <= {sh[6:0], lvl[1]};
         end
         if (re && st == s_ack_t) nack <= lvl[1];
         if (stop || tmo_hit) begin
            st      <= s_idle;
            sda_low <= 1'b0;
            hc      <= 5'h00;
            need_tx <= 1'b0;
            need_rx <= 1'b0;
            ten_ok  <= 1'b0;
            crc     <= 8'h00;
            got_rx  <= 1'b0;
            ev[`E_STOP] <= stop && st != s_idle;
            ev[`E_TMO]  <= tmo_hit;                        // [R10]
            // A bad check byte shows at the end of a received packet.
            ev[`E_PEC]  <= stop && ctrl[`F_PEC] && got_rx
                           && crc != 8'h00;                // [R9]
         end else if (start) begin
            st      <= s_addr;
            hit     <= m_none;
            cnt     <= 4'h0;
            sda_low <= 1'b0;
            hc      <= 5'h00;
            need_tx <= 1'b0;
            need_rx <= 1'b0;
         end else if (load_now) begin
            need_tx <= 1'b0;
            sh      <= tx_byte;
            cnt     <= 4'h0;
            nd      <= ~tx_byte[7];
            hc      <= hold;
         end else if (store_now) begin
            need_rx <= 1'b0;
            got_rx  <= 1'b1;
            ev[`E_RXNE] <= 1'b1;
            st      <= s_ack_r;
            nd      <= 1'b1;
            hc      <= hold;
         end else if (fe) begin
            unique case (st)
               s_idle: begin
               end
               s_addr: begin
                  if (cnt == 4'h8 && a_hit) begin
                     st    <= s_ack_a;
                     nd    <= 1'b1;
                     hc    <= hold;
                     rw    <= sh[0];
                     hdr10 <= h_10 & ~sh[0];
                     ev[`E_ADDR] <= 1'b1;
                     hit <= h_own1 ? m_own1 : h_own2 ? m_own2 :
                            h_10 ? m_ten : h_arp ? m_arp :
                            h_hn ? m_hn : m_ara;
                     // Wakeup only with the digital filter off. [R6] [R7]
                     if (ctrl[`F_WAKE] && stop_mode && dnf == 4'h0)
                        wake <= 1'b1;
                  end else if (cnt == 4'h8) begin
                     st <= s_idle;
                  end
               end
               s_addr2: begin
                  hdr10 <= 1'b0;
                  if (cnt == 4'h8 && sh == own1[7:0]) begin
                     ten_ok <= 1'b1;                       // [R1]
                     st     <= s_ack_a;
                     nd     <= 1'b1;
                     hc     <= hold;
                     ev[`E_ADDR] <= 1'b1;
                  end else if (cnt == 4'h8) begin
                     st <= s_idle;
                  end
               end
               s_ack_a: begin
                  nd  <= 1'b0;
                  hc  <= hold;
                  cnt <= 4'h0;
                  if (hdr10) begin
                     st <= s_addr2;
                  end else if (rw) begin
                     st      <= s_tx;
                     need_tx <= 1'b1;
                     ev[`E_TXIS] <= 1'b1;
                  end else begin
                     st <= s_rx;
                  end
               end
               s_rx: begin
                  if (cnt == 4'h8) need_rx <= 1'b1;
               end
               s_ack_r: begin
                  nd  <= 1'b0;
                  hc  <= hold;
                  cnt <= 4'h0;
                  st  <= s_rx;
               end
               s_tx: begin
                  hc <= hold;
                  if (cnt == 4'h8) begin
                     nd <= 1'b0;
                     st <= s_ack_t;
                  end else begin
                     sh <= {sh[6:0], 1'b0};
                     nd <= ~sh[6];
                  end
               end
               s_ack_t: begin
                  if (nack) begin
                     st <= s_idle;
                     ev[`E_NACK] <= 1'b1;
                  end else begin
                     st      <= s_tx;
                     need_tx <= 1'b1;
                     ev[`E_TXIS] <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Configuration registers written by software.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= `CTRL_RST;
         own1 <= 16'h0000;
         own2 <= 16'h0000;
         ien  <= 8'h00;
      end else if (wr) begin
         if (addr == `A_CTRL) ctrl <= wdata[15:0];
         if (addr == `A_OWN1) own1 <= wdata[15:0];
         if (addr == `A_OWN2) own2 <= wdata[15:0];
         if (addr == `A_IEN)  ien  <= wdata[7:0];
      end
   end

   // Transmit holding byte; a write with the send bit queues the check.
   always_ff @(posedge clk) begin
      if (rst) begin
         txd      <= 8'h00;
         tx_full  <= 1'b0;
         pec_send <= 1'b0;
      end else begin
         if (load_now && pec_send) pec_send <= 1'b0;
         if (load_now && !pec_send) tx_full <= 1'b0;
         if (wr && addr == `A_TXD) begin
            if (wdata[`F_PSEND]) begin
               pec_send <= 1'b1;                           // [R9]
            end else begin
               txd     <= wdata[7:0];
               tx_full <= 1'b1;
            end
         end
      end
   end

   // Receive holding byte; a read empties it, a new byte wins the tie.
   always_ff @(posedge clk) begin
      if (rst) begin
         rxd     <= 8'h00;
         rx_full <= 1'b0;
      end else begin
         if (rd && addr == `A_RXD) rx_full <= 1'b0;
         if (store_now) begin
            rxd     <= sh;
            rx_full <= 1'b1;
         end
      end
   end

   // Alert request; answering the alert response address releases it.
   always_ff @(posedge clk) begin
      if (rst) begin
         alert_req <= 1'b0;
      end else if (wr && addr == `A_ALERT) begin
         alert_req <= wdata[0];
      end else if (ara_take) begin
         alert_req <= 1'b0;                                // [R10]
      end
   end

   // Sticky events; a new event beats a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         ist <= 8'h00;
      end else begin
         ist <= (ist & ~((wr && addr == `A_ICLR) ? wdata[7:0] : 8'h00))
                | ev
                | {ctrl[`F_ALERT] & ~alert_req & pa2 & ~a2, 7'h00};
      end
   end

   // Read data appear in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         unique case (addr)
            `A_CTRL:  rdata <= {16'h0000, ctrl};
            `A_OWN1:  rdata <= {16'h0000, own1};
            `A_OWN2:  rdata <= {16'h0000, own2};
            `A_TXD:   rdata <= {24'h000000, txd};
            `A_RXD:   rdata <= {24'h000000, rxd};
            `A_STAT:  rdata <= {23'h000000, hit, rw, st != s_idle,
                                tx_full, rx_full, pec_send, scl_oe};
            `A_ISTAT: rdata <= {24'h000000, ist};
            `A_IEN:   rdata <= {24'h000000, ien};
            `A_PEC:   rdata <= {24'h000000, crc};
            `A_ALERT: rdata <= {31'h00000000, alert_req};
            default:  rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end

   // Open-drain pins only ever pull low.
   assign scl_out    = 1'b0;
   assign sda_out    = 1'b0;
   assign alert_out  = 1'b0;
   assign scl_oe     = need_tx | need_rx;
   assign sda_oe     = sda_low;
   assign alert_oe   = alert_req;                          // [R10]
   assign irq        = |(ist & ien);
   assign dma_tx_req = ctrl[`F_DTX] & need_tx & ~tx_full
                       & ~pec_send;                        // [R12]
   assign dma_rx_req = ctrl[`F_DRX] & rx_full;             // [R12]
endmodule : i2c_smbus_interface

/* File: tb/i2c_smbus_monitor.sv */
`timescale 1ns/1ps
`include "i2c_smbus_regs.svh"
module i2c_smbus_monitor #(
   parameter int TMO_CYC = 200
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [5:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        scl_in,
   input wire logic        scl_out,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        alert_out,
   input wire logic        stop_mode,
   input wire logic        wake,
   input wire logic        irq,
   input wire logic        dma_tx_req,
   input wire logic        dma_rx_req
);
   logic [15:0] ctrl_q;
   logic [7:0]  ien_q;
   int unsigned low_cnt;

   // Shadow copies of control and enable, taken from the writes seen.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `CTRL_RST;
         ien_q  <= 8'h00;
      end else if (wr && addr == `A_CTRL) begin
         ctrl_q <= wdata[15:0];
      end else if (wr && addr == `A_IEN) begin
         ien_q <= wdata[7:0];
      end
   end

   // Counts raw clock-line low time; it runs slightly ahead of the filtered view.
   always_ff @(posedge clk) begin
      if (rst || scl_in) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= low_cnt + 1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence rd_unmapped;
      rd && addr > `A_ALERT;
   endsequence
   sequence rd_clear_reg;
      rd && addr == `A_ICLR;
   endsequence

   rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   unmapped_zero_a:
   assert property (rd_unmapped or rd_clear_reg |=> rdata == 32'h0)
      else $error("unmapped or write-only offset read not zero");
   irq_masked_a: assert property (ien_q == 8'h00 |-> !irq)
      else $error("interrupt high with all events masked");
   pins_low_a: assert property (!scl_out && !sda_out && !alert_out)
      else $error("open-drain pin drives a high level");
   wake_gate_a:
   assert property ($rose(wake) |->
      stop_mode && ctrl_q[`F_WAKE] && ctrl_q[5:2] == 4'h0)
      else $error("wakeup raised when it is not allowed");
   wake_clear_a: assert property ($fell(stop_mode) |=> !wake)
      else $error("wakeup not cleared after leaving stop");
   dma_rx_gate_a: assert property (dma_rx_req |-> ctrl_q[`F_DRX])
      else $error("receive DMA request while disabled");
   dma_tx_gate_a: assert property (dma_tx_req |-> ctrl_q[`F_DTX])
      else $error("transmit DMA request while disabled");
   sda_change_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line changed while the clock is high");
   tmo_release_a:
   assert property (low_cnt > TMO_CYC + 10 && ctrl_q[`F_TMO] |-> !sda_oe)
      else $error("data line held after a clock timeout");
endmodule : i2c_smbus_monitor

bind i2c_smbus_interface i2c_smbus_monitor #(.TMO_CYC(TMO_CYC)) mon_u (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out),
   .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
   .stop_mode(stop_mode), .wake(wake), .irq(irq),
   .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));

/* File: tb/i2c_ctrl_model.sv */
`timescale 1ns/1ps
module i2c_ctrl_model (
   output logic     scl_low,
   output logic     sda_low,
   input wire logic scl,
   input wire logic sda
);
   int stalls;

   // Lines released at rest, so the clock stands still between frames.
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      stalls  = 0;
   end

   // Data falls while the clock is high, then the clock is pulled low.
   task bus_start;
      sda_low = 1'b1;
      #62.5;
      scl_low = 1'b1;
      #62.5;
   endtask : bus_start

   // Extra low time gives the target room for its hold delay.
   task put_bit(input logic b, input int ext, output logic s);
      int i;
      #31.25;
      sda_low = !b;
      #(31.25 + ext);
      scl_low = 1'b0;
      for (i = 0; i < 5000 && scl !== 1'b1; i++) #10;
      if (i == 5000) stalls++;
      #31.25;
      s = sda;
      #31.25;
      scl_low = 1'b1;
   endtask : put_bit

   // Eight bits, most significant first, then the acknowledge bit.
   task xbyte(input logic [7:0] b, output logic nack);
      logic s;
      for (int k = 7; k >= 0; k--) put_bit(b[k], (k == 7) ? 200 : 0, s);
      put_bit(1'b1, 200, nack);
   endtask : xbyte

   // Data rises while the clock is high.
   task bus_stop;
      sda_low = 1'b1;
      #250;
      scl_low = 1'b0;
      #62.5;
      sda_low = 1'b0;
      #125;
   endtask : bus_stop
endmodule : i2c_ctrl_model

/* File: tb/i2c_smbus_interface_tb.sv */
`timescale 1ns/1ps
`include "i2c_smbus_regs.svh"
module i2c_smbus_interface_tb;
   logic        clk, rst, wr, rd, stop_mode, alert_drv;
   logic [5:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic        scl_oe, sda_oe, alert_oe, wake, irq, nack;
   logic        dma_tx_req, dma_rx_req, scl_low, sda_low;
   logic [6:0]  tbl_a [6] = '{7'h2a, 7'h2b, 7'h43, 7'h44,
                              `ARP_ADDR, `HN_ADDR};
   logic [2:0]  tbl_m [6] = '{3'd1, 3'd0, 3'd2, 3'd0, 3'd4, 3'd5};
   int          n_fail, n_compared;
   // Open-drain lines with pull-ups: whoever pulls low wins.
   wire         scl_line = !(scl_low || scl_oe);
   wire         sda_line = !(sda_low || sda_oe);
   wire         alert_line = alert_drv && !alert_oe;

   i2c_smbus_interface #(.TMO_CYC(200)) dut_u (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .scl_in(scl_line), .scl_out(),
      .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
      .alert_in(alert_line), .alert_out(), .alert_oe(alert_oe),
      .stop_mode(stop_mode), .wake(wake), .irq(irq),
      .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));

   i2c_ctrl_model m_u (.scl_low(scl_low), .sda_low(sda_low),
      .scl(scl_line), .sda(sda_line));

   task check(input string nm, input logic [31:0] seen,
              input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task reg_wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : reg_wr

   task reg_rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   task addr_only(input logic [6:0] a, output logic nk);
      m_u.bus_start;
      m_u.xbyte({a, 1'b0}, nk);
   endtask : addr_only

   // Reference checksum, bit-serial, over a two-byte message.
   function automatic logic [7:0] crc8(input logic [15:0] msg);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ msg[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : crc8

   task give_verdict;
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // Kernel clock of 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Main sequence; each step waits on the model, which bounds its waits.
   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 6'h00; wdata = 32'h0;
      stop_mode = 1'b0; alert_drv = 1'b1; n_fail = 0; n_compared = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      reg_rd(`A_CTRL, v); check("ctrl", v, 32'h2);
      reg_rd(6'h3c, v); check("unmapped", v, 32'h0);
      reg_rd(`A_ICLR, v); check("iclr", v, 32'h0);
      // Fast-plus, filters off, address protocols and alert enabled.
      reg_wr(`A_CTRL, 32'h1381);
      reg_wr(`A_IEN, 32'hff);
      reg_wr(`A_OWN1, 32'h802a);
      reg_wr(`A_OWN2, 32'h8280);
      addr_only(7'h2a, nack); check("ack_a", nack, 0);
      m_u.xbyte(8'ha5, nack); check("ack_d", nack, 0);
      reg_rd(`A_RXD, v); check("rxd", v, 32'ha5);
      m_u.bus_stop;
      reg_rd(`A_ISTAT, v); check("istat", v, 32'h0b);
      check("irq_on", irq, 1);
      reg_wr(`A_IEN, 32'h0); check("irq_mask", irq, 0);
      reg_wr(`A_IEN, 32'hff);
      reg_wr(`A_ICLR, 32'hff);
      reg_rd(`A_ISTAT, v); check("cleared", v, 32'h0);
      check("irq_off", irq, 0);
      // Own, masked, refused and protocol addresses.
      for (int i = 0; i < 6; i++) begin
         addr_only(tbl_a[i], nack);
         check("ack_t", nack, tbl_m[i] == 3'd0);
         reg_rd(`A_STAT, v); check("match", v[8:6], tbl_m[i]);
         m_u.bus_stop;
      end
      // Ten-bit own address: header then low byte.
      reg_wr(`A_OWN1, 32'h86a5);
      m_u.bus_start;
      m_u.xbyte(8'hf4, nack); check("hdr", nack, 0);
      m_u.xbyte(8'ha5, nack); check("low", nack, 0);
      reg_rd(`A_STAT, v); check("ten", v[8:6], 3'd3);
      m_u.bus_stop;
      reg_wr(`A_OWN1, 32'h802a);
      // Checksum byte correct, then off by one bit.
      reg_wr(`A_CTRL, 32'h13c1);
      reg_wr(`A_ICLR, 32'hff);
      for (int k = 0; k < 2; k++) begin
         addr_only(7'h2a, nack);
         m_u.xbyte(8'h5a, nack);
         reg_rd(`A_RXD, v);
         m_u.xbyte(crc8(16'h545a) ^ k[7:0], nack);
         reg_rd(`A_RXD, v);
         m_u.bus_stop;
         reg_rd(`A_ISTAT, v); check("pec", v[5], k[0]);
         reg_wr(`A_ICLR, 32'hff);
      end
      // Receive byte handed over by a DMA request.
      reg_wr(`A_CTRL, 32'hd3c1);
      addr_only(7'h2a, nack);
      m_u.xbyte(8'h33, nack);
      check("dreq", dma_rx_req, 1);
      reg_rd(`A_RXD, v); check("dma_rxd", v, 32'h33);
      check("dreq_off", dma_rx_req, 0);
      m_u.bus_stop;
      // Read addressed: the clock is stretched until a byte is written.
      m_u.bus_start;
      m_u.xbyte(8'h55, nack);
      repeat (8) @(posedge clk);
      check("dtx", dma_tx_req, 1);
      reg_wr(`A_TXD, 32'hff); check("dtx_off", dma_tx_req, 0);
      m_u.bus_stop;
      // Clock held low past the timeout limit.
      reg_wr(`A_CTRL, 32'hb3c1);
      m_u.bus_start;
      repeat (300) @(posedge clk);
      reg_rd(`A_ISTAT, v); check("tmo", v[6], 1);
      m_u.bus_stop;
      // Alert line pulled low by another device.
      @(posedge clk) alert_drv <= 1'b0;
      repeat (10) @(posedge clk);
      alert_drv <= 1'b1;
      reg_rd(`A_ISTAT, v); check("alert", v[7], 1);
      reg_wr(`A_ALERT, 32'h1); check("alert_oe", alert_oe, 1);
      reg_wr(`A_ALERT, 32'h0);
      // Wakeup with the digital filter off, then with three cycles.
      for (int k = 0; k < 2; k++) begin
         reg_wr(`A_CTRL, k ? 32'h17cd : 32'h17c1);
         @(posedge clk) stop_mode <= 1'b1;
         addr_only(7'h2a, nack); check("ack_f", nack, 0);
         m_u.bus_stop;
         check("wake", wake, k == 0);
         @(posedge clk) stop_mode <= 1'b0;
         repeat (2) @(posedge clk);
         check("wake_off", wake, 0);
      end
      check("stalls", m_u.stalls, 0);
      give_verdict;
   end
endmodule : i2c_smbus_interface_tb
